// >>> shared/dastx_defs.svh
`ifndef DASTX_DEFS_SVH
`define DASTX_DEFS_SVH

// Register map
`define DASTX_ADDR_W 16
`define DASTX_CTRL1_ADDR 16'h2801
`define DASTX_CTRL2_ADDR 16'h2802
`define DASTX_STATUS_ADDR 16'h2810
`define DASTX_CTRL1_RST 8'h00
`define DASTX_CTRL2_RST 8'h00
`define DASTX_CTRL1_MASK 8'h04
`define DASTX_STATUS_RSVD 8'h00

// Control 1 field
`define DASTX_RAW_BIT 2

// Control 2 fields
`define DASTX_GEN_BIT 7
`define DASTX_PRO_BIT 6
`define DASTX_NONPCM_BIT 5
`define DASTX_COPY_BIT 4
`define DASTX_PRE_BIT 3
`define DASTX_VCFG_BIT 2
`define DASTX_VOVR_BIT 1
`define DASTX_OEN_BIT 0

// Subframe word layout
`define DASTX_SYNC_MSB 3
`define DASTX_AUD_MSB 27
`define DASTX_AUD_LSB 4
`define DASTX_SMP_MSB 23
`define DASTX_V_POS 28
`define DASTX_U_POS 29
`define DASTX_C_POS 30
`define DASTX_P_POS 31
`define DASTX_SYNC_BLOCK 4'h1
`define DASTX_SYNC_LEFT 4'h2
`define DASTX_SYNC_RIGHT 4'h3

// Channel-status block
`define DASTX_LAST_FRAME 8'hbf
`define DASTX_FIRST_FRAME 8'h00
`define DASTX_FRAME_STEP 8'h01
`define DASTX_CS_PRO 8'h00
`define DASTX_CS_NONPCM 8'h01
`define DASTX_CS_COPY 8'h02
`define DASTX_CS_EMPH 8'h03
`define DASTX_CS_PRO_EMPH0 8'h02
`define DASTX_CS_PRO_EMPH1 8'h03
`define DASTX_CS_GEN 8'h0f

// Data path sizes
`define DASTX_WORD_W 32
`define DASTX_FIFO_DEPTH 4

`endif

// >>> shared/dastx_pkg.sv
`default_nettype none
`include "dastx_defs.svh"

package dastx_pkg;
	typedef enum logic [1:0] {
		DASTX_SLOT_BLOCK,
		DASTX_SLOT_LEFT,
		DASTX_SLOT_RIGHT
	} dastx_slot_t;

	typedef struct packed {
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [7:0] rdata;
		logic [`DASTX_WORD_W-1:0] out_word;
		logic out_valid;
		logic [7:0] frame;
		logic right;
	} dastx_state_t;
endpackage : dastx_pkg

`default_nettype wire

// >>> src/dastx_cs_framer.sv
// Local design decision: the strobed register port.
`default_nettype none
`include "dastx_defs.svh"

// What this block does
// - Control bit 7 sets generation level in consumer format: zero copy, one original
// - Control bit 6 selects consumer (zero) or professional (one) format
// - Control bit 5 flags content: zero linear PCM, one non-PCM data
// - Control bit 4 is copy permission, meaningful only in consumer format
// - Control bit 3 signals 50/15 us pre-emphasis when one
// - Validity configuration bit 2 set forces validity bit 28 to zero
// - Validity bit is zero for a usable sample, one otherwise
// - Override set with configuration clear sets validity in every subframe
// - Output data enable bit 0 clear, the reset value, drives no data
// - Raw mode passes 32-bit words unchanged without channel status
module dastx_cs_framer
	import dastx_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [`DASTX_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Sample stream in
	input wire logic [`DASTX_WORD_W-1:0] smp_data,
	input wire logic smp_err,
	input wire logic smp_valid,
	output logic smp_ready,
	// Subframe stream out
	output logic [`DASTX_WORD_W-1:0] sf_word,
	output logic sf_valid,
	input wire logic sf_ready
);
	localparam int FW = `DASTX_WORD_W + 1;

	dastx_state_t st_ff;
	dastx_state_t nxt_st;

	logic [FW-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;
	logic accept;
	logic raw_mode;
	logic out_en;
	logic [`DASTX_WORD_W-1:0] built_word;
	dastx_slot_t slot;

	function automatic logic reg_hit(input logic [`DASTX_ADDR_W-1:0] addr,
			input logic [`DASTX_ADDR_W-1:0] target);
		reg_hit = (addr == target);
	endfunction : reg_hit

	// Channel-status bit for one frame of the block
	function automatic logic cs_bit(input logic [7:0] idx, input logic [7:0] ctrl);
		logic pro;
		pro = ctrl[`DASTX_PRO_BIT];
		cs_bit = 1'b0;
		if (idx == `DASTX_CS_PRO) begin
			cs_bit = pro;
		end else if (idx == `DASTX_CS_NONPCM) begin
			cs_bit = ctrl[`DASTX_NONPCM_BIT];
		end else if (pro) begin
			// Professional emphasis code: none is 100, 50/15 us is 110
			if (idx == `DASTX_CS_PRO_EMPH0) begin
				cs_bit = 1'b1;
			end else if (idx == `DASTX_CS_PRO_EMPH1) begin
				cs_bit = ctrl[`DASTX_PRE_BIT];
			end
		end else if (idx == `DASTX_CS_COPY) begin
			cs_bit = ctrl[`DASTX_COPY_BIT];
		end else if (idx == `DASTX_CS_EMPH) begin
			cs_bit = ctrl[`DASTX_PRE_BIT];
		end else if (idx == `DASTX_CS_GEN) begin
			cs_bit = ctrl[`DASTX_GEN_BIT];
		end
	endfunction : cs_bit

	// Validity flag from the two control bits and the sample's own error
	function automatic logic validity(input logic [7:0] ctrl, input logic err);
		if (ctrl[`DASTX_VCFG_BIT]) begin
			// Reserved combination with override also lands here
			validity = 1'b0;
		end else if (ctrl[`DASTX_VOVR_BIT]) begin
			validity = 1'b1;
		end else begin
			validity = err;
		end
	endfunction : validity

	function automatic logic [3:0] sync_code(input dastx_slot_t s);
		logic [3:0] code;
		code = `DASTX_SYNC_LEFT;
		case (s)
			DASTX_SLOT_BLOCK: begin
				code = `DASTX_SYNC_BLOCK;
			end
			DASTX_SLOT_LEFT: begin
				code = `DASTX_SYNC_LEFT;
			end
			DASTX_SLOT_RIGHT: begin
				code = `DASTX_SYNC_RIGHT;
			end
			default: begin
				code = `DASTX_SYNC_LEFT;
			end
		endcase
		return code;
	endfunction : sync_code

	// Four-word buffer absorbs the gap between sample arrival and link pace
	dastx_fifo #(
		.WIDTH(FW),
		.DEPTH(`DASTX_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_data({smp_err, smp_data}),
		.in_valid(smp_valid),
		.in_ready(smp_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	assign raw_mode = st_ff.ctrl1[`DASTX_RAW_BIT];
	assign out_en = st_ff.ctrl2[`DASTX_OEN_BIT];
	// Disabled output stops draining, so back-pressure reaches the source
	assign accept = out_en && fifo_valid && (!st_ff.out_valid || sf_ready);
	assign fifo_pop = accept;

	always_comb begin
		slot = DASTX_SLOT_LEFT;
		if (st_ff.right) begin
			slot = DASTX_SLOT_RIGHT;
		end else if (st_ff.frame == `DASTX_FIRST_FRAME) begin
			slot = DASTX_SLOT_BLOCK;
		end
	end

	always_comb begin
		built_word = '0;
		built_word[`DASTX_SYNC_MSB:0] = sync_code(slot);
		built_word[`DASTX_AUD_MSB:`DASTX_AUD_LSB] = fifo_data[`DASTX_SMP_MSB:0];
		built_word[`DASTX_V_POS] = validity(st_ff.ctrl2, fifo_data[FW-1]);
		built_word[`DASTX_U_POS] = 1'b0;
		built_word[`DASTX_C_POS] = cs_bit(st_ff.frame, st_ff.ctrl2);
		built_word[`DASTX_P_POS] = ^built_word[`DASTX_C_POS:`DASTX_AUD_LSB];
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdata = `DASTX_STATUS_RSVD;
		if (reg_wr) begin
			if (reg_hit(reg_addr, `DASTX_CTRL1_ADDR)) begin
				nxt_st.ctrl1 = reg_wdata & `DASTX_CTRL1_MASK;
			end else if (reg_hit(reg_addr, `DASTX_CTRL2_ADDR)) begin
				nxt_st.ctrl2 = reg_wdata;
			end
		end
		if (reg_rd) begin
			if (reg_hit(reg_addr, `DASTX_CTRL1_ADDR)) begin
				nxt_st.rdata = st_ff.ctrl1;
			end else if (reg_hit(reg_addr, `DASTX_CTRL2_ADDR)) begin
				nxt_st.rdata = st_ff.ctrl2;
			end else if (reg_hit(reg_addr, `DASTX_STATUS_ADDR)) begin
				nxt_st.rdata = st_ff.frame;
			end
		end
		if (!out_en) begin
			// A word still waiting when output is disabled is dropped
			nxt_st.out_valid = 1'b0;
			nxt_st.out_word = '0;
		end else if (accept) begin
			nxt_st.out_valid = 1'b1;
			if (raw_mode) begin
				nxt_st.out_word = fifo_data[`DASTX_WORD_W-1:0];
			end else begin
				nxt_st.out_word = built_word;
			end
			nxt_st.right = !st_ff.right;
			if (st_ff.right) begin
				if (st_ff.frame == `DASTX_LAST_FRAME) begin
					nxt_st.frame = `DASTX_FIRST_FRAME;
				end else begin
					nxt_st.frame = st_ff.frame + `DASTX_FRAME_STEP;
				end
			end
		end else if (sf_ready) begin
			nxt_st.out_valid = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= '{ctrl1: `DASTX_CTRL1_RST, ctrl2: `DASTX_CTRL2_RST, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign sf_word = st_ff.out_word;
	assign sf_valid = st_ff.out_valid;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	logic cs_frame_ok;
	assign cs_frame_ok = accept && !raw_mode && !st_ff.right;

	property p_oen_gate;
		sf_valid |-> $past(out_en);
	endproperty
	a_oen_gate: assert property (p_oen_gate) else $error("Output valid while data disabled");

	property p_oen_idle;
		!out_en ##1 !out_en |-> !sf_valid && (sf_word == '0);
	endproperty
	a_oen_idle: assert property (p_oen_idle) else $error("Output driven while disabled");

	property p_raw_pass;
		accept && raw_mode |=> sf_word == $past(fifo_data[`DASTX_WORD_W-1:0]);
	endproperty
	a_raw_pass: assert property (p_raw_pass) else $error("Raw word altered");

	property p_vcfg_clear;
		accept && !raw_mode && st_ff.ctrl2[`DASTX_VCFG_BIT] |=> !sf_word[`DASTX_V_POS];
	endproperty
	a_vcfg_clear: assert property (p_vcfg_clear) else $error("Validity not cleared");

	property p_vovr_set;
		accept && !raw_mode && !st_ff.ctrl2[`DASTX_VCFG_BIT] && st_ff.ctrl2[`DASTX_VOVR_BIT]
			|=> sf_word[`DASTX_V_POS];
	endproperty
	a_vovr_set: assert property (p_vovr_set) else $error("Validity override ignored");

	property p_err_valid;
		accept && !raw_mode && !st_ff.ctrl2[`DASTX_VCFG_BIT] && !st_ff.ctrl2[`DASTX_VOVR_BIT]
			|=> sf_word[`DASTX_V_POS] == $past(fifo_data[FW-1]);
	endproperty
	a_err_valid: assert property (p_err_valid) else $error("Validity does not follow error");

	property p_block_sync;
		cs_frame_ok && (st_ff.frame == `DASTX_FIRST_FRAME)
			|=> sf_word[`DASTX_SYNC_MSB:0] == `DASTX_SYNC_BLOCK;
	endproperty
	a_block_sync: assert property (p_block_sync) else $error("Block start sync missing");

	property p_pro_bit;
		cs_frame_ok && (st_ff.frame == `DASTX_CS_PRO) |=> sf_word[`DASTX_C_POS] == $past(st_ff.ctrl2[`DASTX_PRO_BIT]);
	endproperty
	a_pro_bit: assert property (p_pro_bit) else $error("Format bit wrong");

	property p_nonpcm_bit;
		cs_frame_ok && (st_ff.frame == `DASTX_CS_NONPCM)
			|=> sf_word[`DASTX_C_POS] == $past(st_ff.ctrl2[`DASTX_NONPCM_BIT]);
	endproperty
	a_nonpcm_bit: assert property (p_nonpcm_bit) else $error("Content bit wrong");

	property p_copy_bit;
		cs_frame_ok && (st_ff.frame == `DASTX_CS_COPY) && !st_ff.ctrl2[`DASTX_PRO_BIT]
			|=> sf_word[`DASTX_C_POS] == $past(st_ff.ctrl2[`DASTX_COPY_BIT]);
	endproperty
	a_copy_bit: assert property (p_copy_bit) else $error("Copy bit wrong");

	property p_emph_bit;
		cs_frame_ok && (st_ff.frame == `DASTX_CS_EMPH)
			|=> sf_word[`DASTX_C_POS] == $past(st_ff.ctrl2[`DASTX_PRE_BIT]);
	endproperty
	a_emph_bit: assert property (p_emph_bit) else $error("Emphasis bit wrong");

	property p_gen_bit;
		cs_frame_ok && (st_ff.frame == `DASTX_CS_GEN) && !st_ff.ctrl2[`DASTX_PRO_BIT]
			|=> sf_word[`DASTX_C_POS] == $past(st_ff.ctrl2[`DASTX_GEN_BIT]);
	endproperty
	a_gen_bit: assert property (p_gen_bit) else $error("Generation bit wrong");

	property p_stall_hold;
		sf_valid && !sf_ready && out_en |=> sf_valid && $stable(sf_word);
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("Word lost under stall");

	property p_read_ctrl2;
		reg_rd && reg_hit(reg_addr, `DASTX_CTRL2_ADDR) && !reg_wr |=> reg_rdata == $past(st_ff.ctrl2);
	endproperty
	a_read_ctrl2: assert property (p_read_ctrl2) else $error("Control read wrong");

	property p_cover_raw;
		accept && raw_mode;
	endproperty
	c_cover_raw: cover property (p_cover_raw);

	property p_cover_wrap;
		accept && st_ff.right && (st_ff.frame == `DASTX_LAST_FRAME);
	endproperty
	c_cover_wrap: cover property (p_cover_wrap);

	property p_cover_stall;
		sf_valid && !sf_ready ##1 sf_valid && sf_ready;
	endproperty
	c_cover_stall: cover property (p_cover_stall);

	property p_cover_full;
		smp_valid && !smp_ready;
	endproperty
	c_cover_full: cover property (p_cover_full);
endmodule : dastx_cs_framer

`default_nettype wire

// >>> src/dastx_fifo.sv
`default_nettype none
`include "dastx_defs.svh"

module dastx_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = `DASTX_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Fill side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Drain side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic rdy;
	} dastx_fifo_st_t;

	dastx_fifo_st_t st_ff;
	dastx_fifo_st_t nxt_st;
	logic push;
	logic pop;

	assign push = in_valid && st_ff.rdy;
	assign pop = out_ready && (st_ff.cnt != '0);

	always_comb begin
		nxt_st = st_ff;
		if (push) begin
			nxt_st.mem[st_ff.wp] = in_data;
			nxt_st.wp = (st_ff.wp == LAST) ? '0 : st_ff.wp + 1'b1;
		end
		if (pop) begin
			nxt_st.rp = (st_ff.rp == LAST) ? '0 : st_ff.rp + 1'b1;
		end
		if (push && !pop) begin
			nxt_st.cnt = st_ff.cnt + 1'b1;
		end else if (pop && !push) begin
			nxt_st.cnt = st_ff.cnt - 1'b1;
		end
		// Registered ready keeps the fill side free of a drain-side path
		nxt_st.rdy = (nxt_st.cnt != FULL);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign in_ready = st_ff.rdy;
	assign out_valid = (st_ff.cnt != '0);
	assign out_data = st_ff.mem[st_ff.rp];
endmodule : dastx_fifo

`default_nettype wire

// >>> tb/dastx_rx_model.sv
`default_nettype none

module dastx_rx_model (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Subframe stream
	input wire logic [31:0] sf_word,
	input wire logic sf_valid,
	output logic sf_ready,
	// Bench control
	input wire logic stall,
	input wire logic slow,
	// Words taken
	output logic got,
	output logic [31:0] got_word
);
	timeunit 1ns;
	timeprecision 100ps;
	logic tick_ff;
	// Slow pace takes a word only every other cycle, so the output register must hold
	assign sf_ready = !stall && (!slow || tick_ff);
	always_ff @(posedge clk) begin
		tick_ff <= sys_rst ? 1'b0 : !tick_ff;
		got <= !sys_rst && sf_valid && sf_ready;
		got_word <= sf_word;
	end
endmodule : dastx_rx_model

`default_nettype wire

// >>> tb/digital_audio_tx_channel_status_tb_top.sv
`default_nettype none
`include "dastx_defs.svh"

module digital_audio_tx_channel_status_tb_top
	import dastx_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [31:0] smp_data = 32'h0;
	logic smp_err = 1'b0;
	logic smp_valid = 1'b0;
	logic smp_ready, sf_valid, sf_ready, got;
	logic [31:0] sf_word, got_word;
	logic stall = 1'b0;
	logic slow = 1'b0;
	int errors = 0;
	int checks = 0;
	int frm = 0;
	logic rgt = 1'b0;
	logic raw = 1'b0;
	logic [7:0] cfg = 8'h00;
	logic [31:0] expq[$];
	logic [31:0] seen[$];

	dastx_cs_framer dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smp_data(smp_data), .smp_err(smp_err),
		.smp_valid(smp_valid), .smp_ready(smp_ready), .sf_word(sf_word), .sf_valid(sf_valid),
		.sf_ready(sf_ready));
	dastx_rx_model u_rx (.clk(clk), .sys_rst(sys_rst), .sf_word(sf_word), .sf_valid(sf_valid),
		.sf_ready(sf_ready), .stall(stall), .slow(slow), .got(got), .got_word(got_word));

	always #2 clk = !clk;
	always @(posedge clk) if (got) seen.push_back(got_word);

	// Expected subframe from the live settings and the bench's own frame count
	function automatic logic [31:0] mk(logic [31:0] d, logic e);
		logic c;
		logic v;
		logic [31:0] w;
		if (raw) return d;
		v = cfg[2] ? 1'b0 : (cfg[1] | e);
		if (cfg[6]) c = frm == 0 || frm == 2 || (frm == 1 && cfg[5]) || (frm == 3 && cfg[3]);
		else c = (frm == 1 && cfg[5]) || (frm == 2 && cfg[4]) || (frm == 3 && cfg[3]) || (frm == 15 && cfg[7]);
		w = {1'b0, c, 1'b0, v, d[23:0], rgt ? 4'h3 : (frm == 0 ? 4'h1 : 4'h2)};
		w[31] = ^w[30:4];
		return w;
	endfunction : mk

	task automatic cmp(string what, logic [31:0] exp, logic [31:0] seen_v);
		checks++;
		if (seen_v !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen_v);
		end
	endtask : cmp

	task automatic print_verdict();
		if (errors == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic wr(logic [15:0] a, logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		if (a == `DASTX_CTRL2_ADDR) cfg = d;
		if (a == `DASTX_CTRL1_ADDR) raw = d[2];
	endtask : wr

	task automatic rd(logic [15:0] a, logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 cmp("reg_rdata", {24'h0, exp}, {24'h0, reg_rdata});
	endtask : rd

	task automatic note(logic [31:0] d, logic e);
		expq.push_back(mk(d, e));
		if (rgt) frm = (frm == 191) ? 0 : frm + 1;
		rgt = !rgt;
	endtask : note

	task automatic push(logic [31:0] d, logic e);
		int n;
		@(posedge clk);
		smp_data <= d;
		smp_err <= e;
		smp_valid <= 1'b1;
		n = 0;
		@(posedge clk);
		while (smp_ready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		smp_valid <= 1'b0;
		note(d, e);
	endtask : push

	// A word that never arrives compares against unknown and counts as a mismatch
	task automatic drain();
		int n;
		while (expq.size() > 0) begin
			n = 0;
			while (seen.size() == 0 && n < 200) begin
				@(posedge clk);
				n++;
			end
			cmp("sf_word", expq.pop_front(), seen.size() ? seen.pop_front() : 32'hx);
		end
	endtask : drain

	task automatic t_reset();
		rd(`DASTX_CTRL2_ADDR, 8'h00);
		rd(`DASTX_CTRL1_ADDR, 8'h00);
		wr(16'h2800, 8'hff);
		rd(16'h2800, 8'h00);
		cmp("sf_valid", 32'h0, {31'h0, sf_valid});
	endtask : t_reset

	task automatic t_hold();
		wr(`DASTX_CTRL2_ADDR, 8'h48);
		push(32'h00000111, 1'b0);
		repeat (8) begin
			@(posedge clk);
			cmp("sf_valid", 32'h0, {31'h0, sf_valid});
		end
		wr(`DASTX_CTRL2_ADDR, 8'h49);
		rd(`DASTX_CTRL2_ADDR, 8'h49);
		for (int i = 1; i < 16; i++) push(32'h00010101 * i, i[0]);
		drain();
		rd(`DASTX_STATUS_ADDR, frm[7:0]);
	endtask : t_hold

	task automatic t_valid();
		logic [7:0] c[4] = '{8'h4d, 8'h4b, 8'h4f, 8'h49};
		for (int k = 0; k < 4; k++) begin
			wr(`DASTX_CTRL2_ADDR, c[k]);
			slow <= k[0];
			for (int j = 0; j < 4; j++) push(32'h00c0ffe0 + j, j[0]);
			drain();
		end
		slow <= 1'b0;
	endtask : t_valid

	task automatic t_raw();
		int n;
		n = 0;
		wr(`DASTX_CTRL1_ADDR, 8'hff);
		rd(`DASTX_CTRL1_ADDR, 8'h04);
		while (!(frm == 0 && !rgt)) begin
			push(32'ha5000000 | n, 1'b1);
			n++;
		end
		drain();
		wr(`DASTX_CTRL1_ADDR, 8'h00);
	endtask : t_raw

	task automatic t_consumer();
		wr(`DASTX_CTRL2_ADDR, 8'hb1);
		for (int i = 0; i < 32; i++) push(32'h00123456 + i, i[1]);
		drain();
	endtask : t_consumer

	// Receiver stalls: the FIFO plus the output register take five words, then refuse
	task automatic t_fill();
		int n;
		n = 0;
		stall <= 1'b1;
		@(posedge clk);
		smp_data <= 32'h00abc000;
		smp_err <= 1'b0;
		smp_valid <= 1'b1;
		repeat (20) begin
			@(posedge clk);
			if (smp_ready === 1'b1) begin
				note(smp_data, 1'b0);
				n++;
				smp_data <= smp_data + 32'h1;
			end
		end
		smp_valid <= 1'b0;
		cmp("accepted", 32'd5, n);
		stall <= 1'b0;
		drain();
		repeat (2) @(posedge clk);
		cmp("smp_ready", 32'h1, {31'h0, smp_ready});
	endtask : t_fill

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		print_verdict();
	end

	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_hold();
		t_valid();
		t_raw();
		t_consumer();
		t_fill();
		print_verdict();
	end
endmodule : digital_audio_tx_channel_status_tb_top

`default_nettype wire
